// ---- design/sram_port_consts.svh ----
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BYTE_BITS      9
`define WIDE_DATA_W    36
`define WIDE_LANES     4
`define WIDE_ADDR_W    19
`define NARROW_DATA_W  18
`define NARROW_LANES   2
`define NARROW_ADDR_W  20

// ----------------------------------------------------------------
// burst and latency
// ----------------------------------------------------------------
`define BURST_BEATS    2
`define LAT_DLL_ON     2
`define LAT_DLL_OFF    1

`endif

// ---- design/sram_port_pkg.sv ----
package sram_port_pkg;
	`include "sram_port_consts.svh"

	// sampled pin bundle, each field sized for whichever organisation needs more bits (address from the narrow one)
	typedef struct packed {
		logic                       k;
		logic                       k_n;
		logic                       load_select_n;
		logic                       read_write;
		logic                       doff_n;
		logic [`NARROW_ADDR_W-1:0]  addr;
		logic [`WIDE_LANES-1:0]     byte_lane_write_n;
		logic [`WIDE_DATA_W-1:0]    dq;
	} pins_type;

	typedef struct packed {
		logic                       valid;
		logic [`NARROW_ADDR_W-1:0]  addr;
	} read_req_type;

	typedef enum {
		wb_empty,
		wb_addr,
		wb_beat1,
		wb_full
	} wbuf_state_type;
endpackage

// ---- design/burst_store.sv ----
`timescale 1ns/1ps
module burst_store #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 36,
	parameter int LANES  = 4
) (
	input  wire logic              clk_i,
	input  wire logic              write_i,
	input  wire logic [ADDR_W-1:0] write_addr_i,
	input  wire logic [DATA_W-1:0] beat0_i,
	input  wire logic [DATA_W-1:0] beat1_i,
	input  wire logic [LANES-1:0]  mask0_n_i,
	input  wire logic [LANES-1:0]  mask1_n_i,
	input  wire logic [ADDR_W-1:0] read_addr_i,
	output logic      [DATA_W-1:0] beat0_o,
	output logic      [DATA_W-1:0] beat1_o
);
	localparam int BB = DATA_W / LANES;

	logic [DATA_W-1:0] mem0 [2**ADDR_W];
	logic [DATA_W-1:0] mem1 [2**ADDR_W];

	// masked lanes keep their old contents
	always_ff @(posedge clk_i) begin
		if (write_i) begin
			for (int i = 0; i < LANES; i++) begin
				if (!mask0_n_i[i]) begin
					mem0[write_addr_i][i*BB +: BB] <= beat0_i[i*BB +: BB];
				end
				if (!mask1_n_i[i]) begin
					mem1[write_addr_i][i*BB +: BB] <= beat1_i[i*BB +: BB];
				end
			end
		end
	end

	assign beat0_o = mem0[read_addr_i];
	assign beat1_o = mem1[read_addr_i];
endmodule

// ---- design/dual_rate_burst2_sram_port.sv ----
`timescale 1ns/1ps
`include "sram_port_consts.svh"
module dual_rate_burst2_sram_port
	import sram_port_pkg::*;
#(
	parameter bit  WIDE_ORG = 1'b1,
	localparam int DW       = WIDE_ORG ? `WIDE_DATA_W : `NARROW_DATA_W,
	localparam int LN       = WIDE_ORG ? `WIDE_LANES : `NARROW_LANES,
	localparam int AW       = WIDE_ORG ? `WIDE_ADDR_W : `NARROW_ADDR_W
) (
	input  wire logic                      clk_i,
	input  wire logic                      reset_i,
	input  wire logic                      k_i,
	input  wire logic                      k_n_i,
	input  wire logic                      load_select_n_i,
	input  wire logic                      read_write_i,
	input  wire logic                      doff_n_i,
	input  wire logic [AW-1:0]             address_inputs_i,
	input  wire logic [LN-1:0]             byte_lane_write_n_i,
	input  wire logic [DW-1:0]             dq_i,
	output logic      [DW-1:0]             dq_o,
	output logic                           dq_oe_o,
	output logic                           echo_strobe_o,
	output logic                           echo_strobe_n_o,
	output logic                           output_valid_flag_o
);
	localparam int AMAX = `NARROW_ADDR_W;
	localparam int DMAX = `WIDE_DATA_W;
	localparam int LMAX = `WIDE_LANES;

	function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_word,
			input logic [DW-1:0] new_word, input logic [LN-1:0] mask_n);
		logic [DW-1:0] r;
		r = old_word;
		for (int i = 0; i < LN; i++) begin
			if (!mask_n[i]) begin
				r[i*`BYTE_BITS +: `BYTE_BITS] = new_word[i*`BYTE_BITS +: `BYTE_BITS];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	// the whole bundle shares one two-stage path so data stays aligned
	// with the sampled clock edges
	pins_type raw;
	pins_type sync1;
	pins_type sync2;
	logic     prev_k;
	logic     prev_k_n;
	logic     k_rise;
	logic     k_n_rise;
	always_comb begin
		raw                   = '0;
		raw.k                 = k_i;
		raw.k_n               = k_n_i;
		raw.load_select_n     = load_select_n_i;
		raw.read_write        = read_write_i;
		raw.doff_n            = doff_n_i;
		raw.addr              = AMAX'(address_inputs_i);
		raw.byte_lane_write_n = LMAX'(byte_lane_write_n_i);
		raw.dq                = DMAX'(dq_i);
	end
	always_ff @(posedge clk_i) begin
		sync1    <= raw;
		sync2    <= sync1;
		prev_k   <= sync2.k;
		prev_k_n <= sync2.k_n;
	end
	assign k_rise   = sync2.k & ~prev_k;
	assign k_n_rise = sync2.k_n & ~prev_k_n;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic          take_read;
	logic          take_write;
	logic [AW-1:0] pin_addr;
	logic [DW-1:0] pin_data;
	logic [LN-1:0] pin_mask_n;

	// controls only count on a true rise; deselect leaves address unused
	assign take_read  = k_rise & ~sync2.load_select_n & sync2.read_write;
	assign take_write = k_rise & ~sync2.load_select_n & ~sync2.read_write;
	assign pin_addr   = sync2.addr[AW-1:0];
	assign pin_data   = sync2.dq[DW-1:0];
	assign pin_mask_n = sync2.byte_lane_write_n[LN-1:0];

	// ----------------------------------------------------------------
	// late write buffer
	// ----------------------------------------------------------------
	// one buffer only: a write issued while a write is still collecting
	// its beats is dropped, consistent with alternating address slots
	wbuf_state_type wb_state;
	logic [AW-1:0]  wb_addr_reg;
	logic [DW-1:0]  wb_beat0;
	logic [DW-1:0]  wb_beat1_data;
	logic [LN-1:0]  wb_mask0_n;
	logic [LN-1:0]  wb_mask1_n;
	logic           commit;

	assign commit = k_rise && wb_state == wb_full;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wb_state <= wb_empty;
		end else begin
			case (wb_state)
				wb_empty: begin
					if (take_write) begin
						wb_state <= wb_addr;
					end
				end
				wb_addr: begin
					if (k_rise) begin
						wb_state <= wb_beat1;
					end
				end
				wb_beat1: begin
					if (k_n_rise) begin
						wb_state <= wb_full;
					end
				end
				wb_full: begin
					if (take_write) begin
						wb_state <= wb_addr;
					end else if (k_rise) begin
						wb_state <= wb_empty;
					end
				end
				default: wb_state <= wb_empty;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if ((wb_state == wb_empty || wb_state == wb_full) && take_write) begin
			wb_addr_reg <= pin_addr;
		end
		if (wb_state == wb_addr && k_rise) begin
			wb_beat0   <= pin_data;
			wb_mask0_n <= pin_mask_n;
		end
		if (wb_state == wb_beat1 && k_n_rise) begin
			wb_beat1_data <= pin_data;
			wb_mask1_n    <= pin_mask_n;
		end
	end

	// ----------------------------------------------------------------
	// array and read pipeline
	// ----------------------------------------------------------------
	read_req_type  rd_stage1;
	read_req_type  rd_stage2;
	read_req_type  out_req;
	logic [DW-1:0] array_beat0;
	logic [DW-1:0] array_beat1;
	logic          fwd_hit;
	logic [DW-1:0] next_beat0;
	logic [DW-1:0] next_beat1;
	logic [DW-1:0] beat2_hold;

	burst_store #(
		.ADDR_W (AW),
		.DATA_W (DW),
		.LANES  (LN)
	) store (
		.clk_i        (clk_i),
		.write_i      (commit),
		.write_addr_i (wb_addr_reg),
		.beat0_i      (wb_beat0),
		.beat1_i      (wb_beat1_data),
		.mask0_n_i    (wb_mask0_n),
		.mask1_n_i    (wb_mask1_n),
		.read_addr_i  (out_req.addr[AW-1:0]),
		.beat0_o      (array_beat0),
		.beat1_o      (array_beat1)
	);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_stage1 <= '0;
			rd_stage2 <= '0;
		end else if (k_rise) begin
			rd_stage1 <= '{valid: take_read, addr: AMAX'(pin_addr)};
			rd_stage2 <= rd_stage1;
		end
	end

	// bypassed dll shortens the pipe by one true cycle
	assign out_req = sync2.doff_n ? rd_stage2 : rd_stage1;

	// the array is written on this very edge, so a completed buffer
	// for the same address supplies its unmasked bytes
	assign fwd_hit    = wb_state == wb_full && wb_addr_reg == out_req.addr[AW-1:0];
	assign next_beat0 = fwd_hit ? lane_merge(array_beat0, wb_beat0, wb_mask0_n)
	                            : array_beat0;
	assign next_beat1 = fwd_hit ? lane_merge(array_beat1, wb_beat1_data, wb_mask1_n)
	                            : array_beat1;

	// ----------------------------------------------------------------
	// output drivers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dq_o                <= '0;
			dq_oe_o             <= 1'b0;
			output_valid_flag_o <= 1'b0;
			beat2_hold          <= '0;
		end else if (k_rise) begin
			dq_oe_o             <= out_req.valid;
			output_valid_flag_o <= out_req.valid;
			if (out_req.valid) begin
				dq_o       <= next_beat0;
				beat2_hold <= next_beat1;
			end
		end else if (k_n_rise && dq_oe_o) begin
			dq_o <= beat2_hold;
		end
	end

	// strobes follow the sampled clocks whether or not data is driven
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			echo_strobe_o   <= 1'b0;
			echo_strobe_n_o <= 1'b1;
		end else if (k_rise) begin
			echo_strobe_o   <= 1'b1;
			echo_strobe_n_o <= 1'b0;
		end else if (k_n_rise) begin
			echo_strobe_o   <= 1'b0;
			echo_strobe_n_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_first_beat_time: assert property (
		k_rise && sync2.doff_n && rd_stage2.valid |=> dq_oe_o && output_valid_flag_o)
		else $error("read beat missing two true rises after command");
	a_bypass_latency: assert property (
		k_rise && !sync2.doff_n && rd_stage1.valid |=> dq_oe_o)
		else $error("bypass read beat missing one rise after command");
	a_second_beat: assert property (
		k_n_rise && dq_oe_o && !k_rise |=> dq_o == $past(beat2_hold))
		else $error("second read beat not driven on inverted rise");
	a_echo_pair: assert property (
		echo_strobe_o != echo_strobe_n_o)
		else $error("echo strobes not complementary");
	a_echo_runs: assert property (
		k_n_rise && !k_rise |=> !echo_strobe_o ##0 echo_strobe_n_o)
		else $error("echo strobe stopped on inverted rise");
	a_valid_aligned: assert property (
		$changed(output_valid_flag_o) |-> $past(k_rise) && output_valid_flag_o == dq_oe_o)
		else $error("output valid not aligned with echo edge");
	a_start_on_k: assert property (
		$rose(dq_oe_o) |-> $past(k_rise))
		else $error("bus driven without true rise");
	a_deselect_ignored: assert property (
		k_rise && sync2.load_select_n && wb_state == wb_empty |=> wb_state == wb_empty)
		else $error("deselected cycle started a write");
	a_late_write_addr: assert property (
		take_write && wb_state == wb_empty |=> wb_addr_reg == $past(pin_addr) ##0
		wb_state == wb_addr)
		else $error("write address not held for late write");
	a_forward_data: assert property (
		k_rise && out_req.valid && fwd_hit && wb_mask0_n == '0 |=> dq_o == $past(wb_beat0))
		else $error("pending write data not forwarded");

	c_read_out: cover property (k_rise && out_req.valid ##[1:20] k_n_rise && dq_oe_o);
	c_write_commit: cover property (commit);
	c_forward_hit: cover property (k_rise && out_req.valid && fwd_hit);
	c_bypass_read: cover property (k_rise && !sync2.doff_n && rd_stage1.valid);
endmodule

// ---- sim/sram_ctl_model.sv ----
`timescale 1ns/1ps
`include "sram_port_consts.svh"
module sram_ctl_model (
	input  wire logic                    clk_i,
	output logic                         k_o,
	output logic                         k_n_o,
	output logic                         load_select_n_o,
	output logic                         read_write_o,
	output logic                         doff_n_o,
	output logic [`WIDE_ADDR_W-1:0]      address_o,
	output logic [`WIDE_LANES-1:0]       byte_lane_write_n_o,
	output logic [`WIDE_DATA_W-1:0]      dq_o,
	output logic                         dq_oe_o
);
	// ----
	// input clock pair, 8 clk_i per period, k rises when phase turns 0
	// ----
	logic [2:0] phase = 3'h7;
	int         kcnt  = 0;
	initial begin
		{k_o, k_n_o, load_select_n_o, read_write_o, doff_n_o} = 5'h0f;
		address_o = '0;
		byte_lane_write_n_o = '1;
		dq_o = '0;
		dq_oe_o = 1'b0;
	end
	always @(negedge clk_i) begin
		phase <= phase + 3'h1;
		k_o <= (phase == 3'h7) || (phase < 3'h3);
		k_n_o <= !((phase == 3'h7) || (phase < 3'h3));
		if (phase == 3'h7) kcnt <= kcnt + 1;
	end
	task automatic wait_ph(input logic [2:0] p);
		do @(negedge clk_i); while (phase != p);
	endtask
	// commands straddle a k rise only, never the k# rise
	task automatic issue(input logic rd, input logic [`WIDE_ADDR_W-1:0] a, output int c);
		wait_ph(3'h5);
		load_select_n_o = 1'b0;
		read_write_o = rd;
		address_o = a;
		wait_ph(3'h1);
		c = kcnt;
		load_select_n_o = 1'b1;
		read_write_o = ~rd;
		address_o = ~a;
	endtask
	// a select that only covers the k# rise must not start anything
	task automatic fall_only(input logic [`WIDE_ADDR_W-1:0] a);
		wait_ph(3'h1);
		load_select_n_o = 1'b0;
		read_write_o = 1'b1;
		address_o = a;
		wait_ph(3'h5);
		load_select_n_o = 1'b1;
	endtask
	task automatic wdata(input logic [`WIDE_DATA_W-1:0] d0, input logic [3:0] m0,
			input logic [`WIDE_DATA_W-1:0] d1, input logic [3:0] m1);
		wait_ph(3'h5);
		dq_oe_o = 1'b1;
		dq_o = d0;
		byte_lane_write_n_o = m0;
		wait_ph(3'h1);
		dq_o = d1;
		byte_lane_write_n_o = m1;
		wait_ph(3'h5);
		// released lines show garbage, not the last beat
		dq_oe_o = 1'b0;
		dq_o = ~d1;
		byte_lane_write_n_o = '1;
	endtask
	task automatic set_doff(input logic v);
		wait_ph(3'h5);
		doff_n_o = v;
	endtask
endmodule

// ---- sim/dual_rate_burst2_sram_port_test.sv ----
`timescale 1ns/1ps
`include "sram_port_consts.svh"
module dual_rate_burst2_sram_port_test;
	import sram_port_pkg::*;
	localparam int DW = `WIDE_DATA_W;
	logic                       clk_i = 1'b0;
	logic                       reset_i = 1'b1;
	logic                       k, kn, ld, rw, doff, coe, oe, vld, echo, echo_n;
	logic [`WIDE_ADDR_W-1:0]    addr;
	logic [3:0]                 bw;
	logic [DW-1:0]              cdq, udq, dq_bus;
	int                         num_errors = 0;
	int                         cmp_count = 0;
	always #12.5 clk_i = ~clk_i;
	assign dq_bus = oe ? udq : cdq;
	sram_ctl_model ctl (.clk_i(clk_i), .k_o(k), .k_n_o(kn), .load_select_n_o(ld),
		.read_write_o(rw), .doff_n_o(doff), .address_o(addr), .byte_lane_write_n_o(bw),
		.dq_o(cdq), .dq_oe_o(coe));
	dual_rate_burst2_sram_port #(.WIDE_ORG(1'b1)) uut (.clk_i(clk_i), .reset_i(reset_i),
		.k_i(k), .k_n_i(kn), .load_select_n_i(ld), .read_write_i(rw), .doff_n_i(doff),
		.address_inputs_i(addr), .byte_lane_write_n_i(bw), .dq_i(dq_bus), .dq_o(udq),
		.dq_oe_o(oe), .echo_strobe_o(echo), .echo_strobe_n_o(echo_n),
		.output_valid_flag_o(vld));
	// ----
	// checking helpers
	// ----
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic mismatch(input string msg);
		num_errors++;
		$display("MISMATCH at %0t: %s", $time, msg);
	endtask
	task automatic check_bit(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp) mismatch(msg);
	endtask
	task automatic check_word(input logic [DW-1:0] got, input logic [DW-1:0] exp, string msg);
		cmp_count++;
		if (got !== exp) mismatch(msg);
	endtask
	task automatic wait_sig(ref logic s, input logic v);
		int n;
		for (n = 0; n < 48 && s !== v; n++) @(negedge clk_i);
		if (s !== v) begin
			mismatch("wait ran out");
			print_verdict();
		end
	endtask
	function automatic logic [DW-1:0] merge(logic [DW-1:0] old, nw, logic [3:0] m);
		merge = old;
		for (int i = 0; i < 4; i++) if (!m[i]) merge[9*i +: 9] = nw[9*i +: 9];
	endfunction
	always @(negedge clk_i) if (oe === 1'b1 && coe === 1'b1) mismatch("bus contention");
	// ----
	// scenarios
	// ----
	localparam logic [18:0] A1 = 19'h01234;
	localparam logic [18:0] B1 = 19'h7fffe;
	localparam logic [DW-1:0] D0 = 36'h123456789, D1 = 36'h987654321, N0 = 36'h5a5a5a5a5;
	task automatic rd_check(logic [18:0] a, int lat, logic [DW-1:0] e0, e1);
		int c;
		ctl.issue(1'b1, a, c);
		wait_sig(vld, 1'b1);
		check_bit(ctl.kcnt == c + lat, 1'b1, "read latency");
		check_bit(oe, 1'b1, "drive with valid");
		check_bit(echo, 1'b1, "echo rise with beat0");
		check_word(udq, e0, "first read beat");
		wait_sig(echo, 1'b0);
		check_word(udq, e1, "second read beat");
		check_bit(vld, 1'b1, "valid over both beats");
		repeat (16) @(negedge clk_i);
		check_bit(oe, 1'b0, "bus released after burst");
		check_bit(vld, 1'b0, "valid dropped after burst");
	endtask
	task automatic t_idle_strobes();
		int n;
		logic p;
		n = 0;
		repeat (8) @(negedge clk_i);
		p = echo;
		repeat (16) begin
			@(negedge clk_i);
			if (echo !== p) n++;
			p = echo;
			check_bit(echo_n, ~echo, "echo pair");
		end
		check_bit(n == 4, 1'b1, "echo runs while idle");
	endtask
	task automatic t_write_read();
		int c;
		ctl.issue(1'b0, A1, c);
		ctl.wdata(D0, 4'h0, D1, 4'h0);
		rd_check(A1, 2, D0, D1);
		ctl.issue(1'b0, A1, c);
		ctl.wdata(N0, 4'h5, ~N0, 4'ha);
		rd_check(A1, 2, merge(D0, N0, 4'h5), merge(D1, ~N0, 4'ha));
	endtask
	task automatic t_forward();
		int c;
		ctl.issue(1'b0, B1, c);
		fork
			ctl.wdata(D1, 4'h0, D0, 4'h0);
			rd_check(B1, 2, D1, D0);
		join
		// only the one-cycle pipe puts a read on the commit edge
		ctl.set_doff(1'b0);
		repeat (16) @(negedge clk_i);
		ctl.issue(1'b0, B1, c);
		fork
			ctl.wdata(N0, 4'h0, ~N0, 4'ha);
			rd_check(B1, 1, N0, merge(D0, ~N0, 4'ha));
		join
		ctl.set_doff(1'b1);
		repeat (16) @(negedge clk_i);
	endtask
	task automatic t_fall_only();
		int n;
		n = 0;
		ctl.fall_only(B1);
		repeat (32) begin
			@(negedge clk_i);
			if (vld !== 1'b0) n++;
		end
		check_bit(n == 0, 1'b1, "k# rise started a read");
	endtask
	task automatic t_doff();
		ctl.set_doff(1'b0);
		repeat (16) @(negedge clk_i);
		rd_check(B1, 1, N0, merge(D0, ~N0, 4'ha));
		ctl.set_doff(1'b1);
		repeat (16) @(negedge clk_i);
		rd_check(B1, 2, N0, merge(D0, ~N0, 4'ha));
	endtask
	initial begin
		repeat (10) @(negedge clk_i);
		check_bit(vld, 1'b0, "valid in reset");
		check_bit(echo_n, 1'b1, "echo_n in reset");
		reset_i = 1'b0;
		t_idle_strobes();
		t_write_read();
		t_forward();
		t_fall_only();
		t_doff();
		print_verdict();
	end
endmodule
